// ==== verilog/ioexp_pkg.sv ====
// shared constants and types of the two-lane serial i/o expander
package ioexp_pkg;

    localparam int          LANE_W    = 8;
    localparam int          PIN_W     = 2 * LANE_W;
    localparam int          NREG      = 12;
    // fixed upper five bits of the 7-bit target address
    localparam logic [4:0]  ADDR_BASE = 5'h1d;

    // register pointer values carried by the command byte
    localparam logic [3:0]  REG_IN0   = 4'h0;
    localparam logic [3:0]  REG_IN1   = 4'h1;
    localparam logic [3:0]  REG_OUT0  = 4'h2;
    localparam logic [3:0]  REG_POL0  = 4'h4;
    localparam logic [3:0]  REG_CFG0  = 4'h6;
    localparam logic [3:0]  REG_MODE0 = 4'h8;
    localparam logic [3:0]  REG_ANOM0 = 4'ha;
    localparam logic [3:0]  REG_LAST  = 4'hb;

    // register defaults: all pins inputs, outputs high, push-pull
    localparam logic [7:0]  RST_OUT   = 8'hff;
    localparam logic [7:0]  RST_POL   = 8'h00;
    localparam logic [7:0]  RST_CFG   = 8'hff;
    localparam logic [7:0]  RST_MODE  = 8'h00;
    localparam logic [7:0]  RST_ANOM  = 8'h00;

    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_ADDR  = 8'h02,
        ST_ACK_A = 8'h04,
        ST_CMD   = 8'h08,
        ST_ACK_W = 8'h10,
        ST_WDATA = 8'h20,
        ST_RDATA = 8'h40,
        ST_MACK  = 8'h80
    } link_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_lvl_t;

    typedef struct packed {
        logic [PIN_W-1:0] lvl;
        logic [PIN_W-1:0] oe;
    } pin_drive_t;

    // default value of a register by pointer; input slots read as zero
    function automatic logic [7:0] reg_default(input logic [3:0] idx);
        logic [2:0] grp;
        grp = idx[3:1];
        case (grp)
            REG_OUT0[3:1]:  reg_default = RST_OUT;
            REG_POL0[3:1]:  reg_default = RST_POL;
            REG_CFG0[3:1]:  reg_default = RST_CFG;
            REG_MODE0[3:1]: reg_default = RST_MODE;
            REG_ANOM0[3:1]: reg_default = RST_ANOM;
            default:        reg_default = 8'h00;
        endcase
    endfunction

endpackage

// ==== verilog/ioexp_top.sv ====
// two-lane serial i/o expander: target port, registers, pins and alert
// What this block does
// - after any reset every pin is input and registers hold defaults
// - two lanes of readable 8-bit input, output, polarity, direction, mode, anomaly
// - direction register sets each pin input or output bit by bit
// - polarity bit 1 inverts the pin level read from the input register
// - mode register picks push-pull or open-drain per output pin
// - input pins are left undriven, both drivers off
// - push-pull output pins drive the level of their output register bit
// - alert asserts when an input pin differs from its captured value
// - enabled anomaly: output pin level differing from its bit asserts alert
// - alert releases when pins return or, for input changes, the lane input is read
// - read release happens at the acknowledge before the data byte
// - a pin change during that acknowledge may be lost; accepted
// - transfers to other targets leave the alert untouched
// - alert capture is per lane; reading one lane never clears the other
// - turning an output into an input may raise an alert
// - hardware clear low resets the link machine and holds defaults
// - stay in reset until power good, then load defaults
// - two select pins form the low address bits, four devices per bus
// - alert is open-drain active low, pulls low only
// - target address is 0x74 to 0x77; last bit 1 reads, 0 writes
// - command byte low four bits pick the register, upper four zero
// - a read before any command byte is not acknowledged
// - multi-byte reads alternate between the two lanes of the pair
`timescale 1ns/100ps
`default_nettype none

module ioexp_top
    import ioexp_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_b,
    input  wire logic              i_hw_clear_in_n,
    input  wire logic              i_power_good,
    input  wire logic              i_addr_sel_lo,
    input  wire logic              i_addr_sel_hi,
    input  wire logic              i_scl,
    input  wire logic              i_sda,
    output logic                   o_sda,
    output logic                   o_sda_oe,
    input  wire logic [LANE_W-1:0] i_lane0_pins,
    input  wire logic [LANE_W-1:0] i_lane1_pins,
    output logic      [LANE_W-1:0] o_lane0_pins,
    output logic      [LANE_W-1:0] o_lane0_pins_oe,
    output logic      [LANE_W-1:0] o_lane1_pins,
    output logic      [LANE_W-1:0] o_lane1_pins_oe,
    output logic                   o_change_alert_n,
    output logic                   o_change_alert_n_oe
);

    logic [1:0]       rst_s;
    logic             rst_n;
    bus_lvl_t         bus_s1, bus_s2, bus_s3;
    logic [PIN_W-1:0] pin_s1, pin_s2;
    logic [1:0]       hwc_s, pg_s;
    logic             clr;

    // reset release through two flops
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_s <= 2'b00;
        end else begin
            rst_s <= {rst_s[0], 1'b1};
        end
    end
    assign rst_n = rst_s[1];

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bus_s1 <= '1;
            bus_s2 <= '1;
            bus_s3 <= '1;
            pin_s1 <= '0;
            pin_s2 <= '0;
            hwc_s  <= 2'b00;
            pg_s   <= 2'b00;
        end else begin
            bus_s1 <= '{scl: i_scl, sda: i_sda};
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
            pin_s1 <= {i_lane1_pins, i_lane0_pins};
            pin_s2 <= pin_s1;
            hwc_s  <= {hwc_s[0], i_hw_clear_in_n};
            pg_s   <= {pg_s[0], i_power_good};
        end
    end

    // clear or no power good holds defaults
    assign clr = ~hwc_s[1] | ~pg_s[1];

    logic scl_rise, scl_fall, bus_start, bus_stop;
    // edges seen only on the second and third stages
    assign scl_rise  = bus_s2.scl & ~bus_s3.scl;
    assign scl_fall  = ~bus_s2.scl & bus_s3.scl;
    assign bus_start = bus_s2.scl & bus_s3.scl & bus_s3.sda & ~bus_s2.sda;
    assign bus_stop  = bus_s2.scl & bus_s3.scl & ~bus_s3.sda & bus_s2.sda;

    link_state_t       st_r, st_nxt;
    logic [2:0]        bit_r, bit_nxt;
    logic [7:0]        sh_r, sh_nxt, tx_r, tx_nxt;
    logic [3:0]        ptr_r, ptr_nxt;
    logic              cmdv_r, cmdv_nxt, rw_r, rw_nxt;
    logic              sda_oe_r, sda_oe_nxt;
    logic [PIN_W-1:0]  snap_r, snap_nxt;
    logic [7:0]        reg_r   [NREG];
    logic [7:0]        reg_nxt [NREG];
    logic [1:0]        rd_ev;
    logic              addr_done, addr_hit;

    // target address decode on the eighth address bit
    assign addr_done = (st_r == ST_ADDR) && scl_rise && (bit_r == 3'd7);
    // fixed base plus the two select pins
    assign addr_hit  = {sh_r[6:2], sh_r[1:0]}
                       == {ADDR_BASE, i_addr_sel_hi, i_addr_sel_lo};

    // link state machine, register writes and read captures
    always_comb begin
        logic [7:0] sh_in;
        logic       load;
        logic [3:0] lptr;
        logic       lane;
        sh_in      = {sh_r[6:0], bus_s2.sda};
        load       = 1'b0;
        lptr       = ptr_r;
        lane       = ptr_r[0];
        st_nxt     = st_r;
        bit_nxt    = bit_r;
        sh_nxt     = sh_r;
        tx_nxt     = tx_r;
        ptr_nxt    = ptr_r;
        cmdv_nxt   = cmdv_r;
        rw_nxt     = rw_r;
        sda_oe_nxt = sda_oe_r;
        snap_nxt   = snap_r;
        rd_ev      = 2'b00;
        for (int i = 0; i < NREG; i++) begin
            reg_nxt[i] = reg_r[i];
        end
        // stop always returns the machine to idle
        if (bus_stop) begin
            st_nxt     = ST_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (bus_start) begin
            st_nxt     = ST_ADDR;
            bit_nxt    = 3'd0;
            sda_oe_nxt = 1'b0;
        end else if (scl_fall) begin
            // data changes only while the clock is low
            sda_oe_nxt = (st_r == ST_ACK_A) || (st_r == ST_ACK_W)
                         || ((st_r == ST_RDATA) && !tx_r[3'd7 - bit_r]);
        end else if (scl_rise) begin
            case (st_r)
                ST_ADDR: begin
                    sh_nxt  = sh_in;
                    bit_nxt = bit_r + 3'd1;
                    if (bit_r == 3'd7) begin
                        // foreign or early read: no ack
                        if (addr_hit && (!sh_in[0] || cmdv_r)) begin
                            st_nxt = ST_ACK_A;
                            rw_nxt = sh_in[0];
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
                ST_ACK_A: begin
                    bit_nxt = 3'd0;
                    if (rw_r) begin
                        // capture and release at the ack rise
                        load   = 1'b1;
                        st_nxt = ST_RDATA;
                    end else begin
                        st_nxt = ST_CMD;
                    end
                end
                ST_CMD: begin
                    sh_nxt  = sh_in;
                    bit_nxt = bit_r + 3'd1;
                    if (bit_r == 3'd7) begin
                        // only pointers with a zero upper nibble
                        if (sh_in[7:4] == 4'h0 && sh_in[3:0] <= REG_LAST) begin
                            ptr_nxt  = sh_in[3:0];
                            cmdv_nxt = 1'b1;
                            st_nxt   = ST_ACK_W;
                        end else begin
                            st_nxt = ST_IDLE;
                        end
                    end
                end
                ST_ACK_W: begin
                    bit_nxt = 3'd0;
                    st_nxt  = ST_WDATA;
                end
                ST_WDATA: begin
                    sh_nxt  = sh_in;
                    bit_nxt = bit_r + 3'd1;
                    if (bit_r == 3'd7) begin
                        if (ptr_r >= REG_OUT0) begin
                            reg_nxt[ptr_r] = sh_in;
                        end
                        ptr_nxt = {ptr_r[3:1], ~ptr_r[0]};
                        st_nxt  = ST_ACK_W;
                    end
                end
                ST_RDATA: begin
                    bit_nxt = bit_r + 3'd1;
                    if (bit_r == 3'd7) begin
                        st_nxt = ST_MACK;
                    end
                end
                ST_MACK: begin
                    bit_nxt = 3'd0;
                    if (!bus_s2.sda) begin
                        // next byte comes from the other lane
                        lptr    = {ptr_r[3:1], ~ptr_r[0]};
                        ptr_nxt = lptr;
                        load    = 1'b1;
                        st_nxt  = ST_RDATA;
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
        // every register readable, inputs inverted per bit
        if (load) begin
            lane = lptr[0];
            if (lptr <= REG_IN1) begin
                tx_nxt = pin_s2[lane*LANE_W +: LANE_W]
                         ^ reg_r[REG_POL0 + {3'd0, lane}];
                snap_nxt[lane*LANE_W +: LANE_W] = pin_s2[lane*LANE_W +: LANE_W];
                rd_ev[lane] = 1'b1;
            end else begin
                tx_nxt = reg_r[lptr];
            end
        end
        if (clr) begin
            st_nxt     = ST_IDLE;
            cmdv_nxt   = 1'b0;
            ptr_nxt    = REG_IN0;
            sda_oe_nxt = 1'b0;
            snap_nxt   = pin_s2;
            for (int i = 0; i < NREG; i++) begin
                reg_nxt[i] = reg_default(4'(i));
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= ST_IDLE;
            bit_r    <= 3'd0;
            sh_r     <= 8'h00;
            tx_r     <= 8'h00;
            ptr_r    <= REG_IN0;
            cmdv_r   <= 1'b0;
            rw_r     <= 1'b0;
            sda_oe_r <= 1'b0;
            snap_r   <= '0;
            for (int i = 0; i < NREG; i++) begin
                reg_r[i] <= reg_default(4'(i));
            end
        end else begin
            st_r     <= st_nxt;
            bit_r    <= bit_nxt;
            sh_r     <= sh_nxt;
            tx_r     <= tx_nxt;
            ptr_r    <= ptr_nxt;
            cmdv_r   <= cmdv_nxt;
            rw_r     <= rw_nxt;
            sda_oe_r <= sda_oe_nxt;
            snap_r   <= snap_nxt;
            reg_r    <= reg_nxt;
        end
    end

    logic [PIN_W-1:0] out_all, cfg_all, mode_all, anom_all;
    logic [1:0]       pend;
    pin_drive_t       drv_nxt, drv_r;
    logic             alert_nxt, alert_r;

    assign out_all  = {reg_r[REG_OUT0 + 4'd1], reg_r[REG_OUT0]};
    assign cfg_all  = {reg_r[REG_CFG0 + 4'd1], reg_r[REG_CFG0]};
    assign mode_all = {reg_r[REG_MODE0 + 4'd1], reg_r[REG_MODE0]};
    assign anom_all = {reg_r[REG_ANOM0 + 4'd1], reg_r[REG_ANOM0]};

    // pin drivers and alert sources per lane
    always_comb begin
        drv_nxt.lvl = ~cfg_all & ~mode_all & out_all;
        drv_nxt.oe  = ~cfg_all & (~mode_all | ~out_all);
        for (int l = 0; l < 2; l++) begin
            // mismatch is a level, not an event
            pend[l] = |((pin_s2[l*LANE_W +: LANE_W] ^ snap_r[l*LANE_W +: LANE_W])
                        & cfg_all[l*LANE_W +: LANE_W])
                    | |((pin_s2[l*LANE_W +: LANE_W] ^ out_all[l*LANE_W +: LANE_W])
                        & ~cfg_all[l*LANE_W +: LANE_W]
                        & anom_all[l*LANE_W +: LANE_W]);
        end
        // change during the clearing ack may show only briefly
        alert_nxt = |pend & ~clr;
    end

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            drv_r   <= '0;
            alert_r <= 1'b0;
        end else begin
            drv_r   <= drv_nxt;
            alert_r <= alert_nxt;
        end
    end

    // both open-drain lines only ever drive low
    assign o_sda               = 1'b0;
    assign o_change_alert_n    = 1'b0;
    assign o_sda_oe            = sda_oe_r;
    assign o_change_alert_n_oe = alert_r;
    assign o_lane0_pins        = drv_r.lvl[LANE_W-1:0];
    assign o_lane1_pins        = drv_r.lvl[PIN_W-1:LANE_W];
    assign o_lane0_pins_oe     = drv_r.oe[LANE_W-1:0];
    assign o_lane1_pins_oe     = drv_r.oe[PIN_W-1:LANE_W];

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n);

    // read bit as it enters the shifter on the eighth address rise
    logic sh_in_rd;
    assign sh_in_rd = bus_s2.sda;
    sequence s_early_read;
        addr_done && addr_hit && sh_in_rd && !cmdv_r;
    endsequence

    chk_clear_inputs: assert property (
        clr ##1 clr |=> (drv_r.oe == '0)) else $error("pins driven in clear");
    chk_input_hiz: assert property (
        ##1 ((drv_r.oe & $past(cfg_all)) == '0)) else $error("input pin driven");
    chk_output_level: assert property (
        ##1 ((drv_r.lvl ^ $past(out_all)) & ~$past(cfg_all) & ~$past(mode_all))
        == '0) else $error("push-pull level wrong");
    chk_opendrain_low: assert property (
        ##1 ((drv_r.lvl | (drv_r.oe ^ ~$past(out_all)))
        & ~$past(cfg_all) & $past(mode_all)) == '0) else $error("open-drain wrong");
    chk_alert_follow: assert property (
        (|pend && !clr) |=> o_change_alert_n_oe) else $error("alert missed");
    chk_read_capture: assert property (
        rd_ev[0] && !clr |=> snap_r[LANE_W-1:0] == $past(pin_s2[LANE_W-1:0])
        && $stable(snap_r[PIN_W-1:LANE_W])) else $error("lane capture wrong");
    chk_early_nack: assert property (
        (s_early_read and !clr) |=> st_r == ST_IDLE ##1 !sda_oe_r)
        else $error("read acked without command");
    chk_foreign_idle: assert property (
        addr_done && !addr_hit && !clr && !bus_stop
        |=> st_r == ST_IDLE && $stable(snap_r)) else $error("foreign address taken");
    chk_pair_toggle: assert property (
        st_r == ST_MACK && scl_rise && !bus_s2.sda && !clr && !bus_stop
        && !bus_start |=> ptr_r[0] != $past(ptr_r[0])) else $error("no lane swap");
    chk_alert_od: assert property (
        !o_change_alert_n && !o_sda) else $error("open-drain drives high");

endmodule

`default_nettype wire

// ==== tb/i2c_ctrl_model.sv ====
// serial bus controller model that drives the expander target port
`timescale 1ns/100ps
`default_nettype none

module i2c_ctrl_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_sda,
    output logic            o_scl,
    output logic            o_sda_oe,
    output logic            o_rd_valid,
    output logic [7:0]      o_rd_data
);
    // bus idle: scl parked high, sda released to its pull-up
    initial begin
        o_scl      = 1'b1;
        o_sda_oe   = 1'b0;
        o_rd_valid = 1'b0;
        o_rd_data  = 8'h00;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // data moves only while scl is low; high half is four clocks
    task automatic bit_out(input logic b);
        o_sda_oe <= ~b;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_scl <= 1'b0;
        tick(2);
    endtask
    // sampled mid-high, well after the target's sync delay
    task automatic bit_in(output logic b);
        o_sda_oe <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(2);
        b = i_sda;
        tick(2);
        o_scl <= 1'b0;
        tick(2);
    endtask
    task automatic start();
        tick(4);
        o_sda_oe <= 1'b1;
        tick(4);
        o_scl <= 1'b0;
        tick(2);
    endtask
    // repeated start, entered with scl low
    task automatic restart();
        o_sda_oe <= 1'b0;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_oe <= 1'b1;
        tick(4);
        o_scl <= 1'b0;
        tick(2);
    endtask
    // stop leaves both lines high, so the bus is idle again
    task automatic stop();
        o_sda_oe <= 1'b1;
        tick(2);
        o_scl <= 1'b1;
        tick(4);
        o_sda_oe <= 1'b0;
        tick(4);
    endtask
    // byte out msb first, then the target's acknowledge
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(a);
        ack = ~a;
    endtask
    // byte in, one-cycle valid pulse, then ack or final nack
    task automatic rd_byte(input logic last);
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        o_rd_data  <= d;
        o_rd_valid <= 1'b1;
        tick(1);
        o_rd_valid <= 1'b0;
        bit_out(last);
    endtask
endmodule

`default_nettype wire

// ==== tb/ioexp_top_tb.sv ====
// self-checking bench for the two-lane serial i/o expander
`timescale 1ns/100ps
`default_nettype none

module ioexp_top_tb;
    import ioexp_pkg::*;

    logic              clk, rst_b, clr_n, pgood, a;
    logic              scl, c_oe, d_sda, d_oe, sda, rd_v, al, al_oe, alert_n;
    logic [7:0]        ext0, ext1, p0, p1, o0, o1, oe0, oe1, rd_d;
    logic [7:0]        pol0, out0, dir0;
    logic [7:0]        exp_q[$];
    int                err_count, n_checks;
    integer            seed = 16831;
    localparam logic   SEL_HI = 1'b1;
    localparam logic   SEL_LO = 1'b0;
    localparam logic [7:0] DFLT [6] = '{8'h00, RST_OUT, RST_POL, RST_CFG,
                                        RST_MODE, RST_ANOM};

    // pulled-up open-drain wires; pins show whichever side drives
    assign sda     = (d_oe ? d_sda : 1'b1) & ~c_oe;
    assign alert_n = al_oe ? al : 1'b1;
    assign p0      = (oe0 & o0) | (~oe0 & ext0);
    assign p1      = (oe1 & o1) | (~oe1 & ext1);

    ioexp_top i_ioexp_top (
        .i_clk_sys           (clk),
        .i_rst_b             (rst_b),
        .i_hw_clear_in_n     (clr_n),
        .i_power_good        (pgood),
        .i_addr_sel_lo       (SEL_LO),
        .i_addr_sel_hi       (SEL_HI),
        .i_scl               (scl),
        .i_sda               (sda),
        .o_sda               (d_sda),
        .o_sda_oe            (d_oe),
        .i_lane0_pins        (p0),
        .i_lane1_pins        (p1),
        .o_lane0_pins        (o0),
        .o_lane0_pins_oe     (oe0),
        .o_lane1_pins        (o1),
        .o_lane1_pins_oe     (oe1),
        .o_change_alert_n    (al),
        .o_change_alert_n_oe (al_oe)
    );
    i2c_ctrl_model i_i2c_ctrl_model (
        .i_clk_sys  (clk),
        .i_sda      (sda),
        .o_scl      (scl),
        .o_sda_oe   (c_oe),
        .o_rd_valid (rd_v),
        .o_rd_data  (rd_d)
    );

    // 25 MHz system clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic cmp1(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic cmp8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    function automatic logic [7:0] adr(input logic rd);
        adr = {ADDR_BASE, SEL_HI, SEL_LO, rd};
    endfunction
    // register pair write; address, command and second data byte checked for ack
    task automatic wr_pair(input logic [3:0] p, input logic [7:0] d0,
                           input logic [7:0] d1);
        i_i2c_ctrl_model.start();
        i_i2c_ctrl_model.wr_byte(adr(1'b0), a);
        cmp1("ack_adr", 1'b1, a);
        i_i2c_ctrl_model.wr_byte({4'h0, p}, a);
        cmp1("ack_cmd", 1'b1, a);
        i_i2c_ctrl_model.wr_byte(d0, a);
        i_i2c_ctrl_model.wr_byte(d1, a);
        cmp1("ack_dat", 1'b1, a);
        i_i2c_ctrl_model.stop();
    endtask
    task automatic rd_regs(input logic [3:0] p, input logic [7:0] e0,
                           input logic [7:0] e1, input logic two);
        i_i2c_ctrl_model.start();
        i_i2c_ctrl_model.wr_byte(adr(1'b0), a);
        i_i2c_ctrl_model.wr_byte({4'h0, p}, a);
        i_i2c_ctrl_model.restart();
        i_i2c_ctrl_model.wr_byte(adr(1'b1), a);
        cmp1("ack_rd", 1'b1, a);
        exp_q.push_back(e0);
        i_i2c_ctrl_model.rd_byte(~two);
        if (two) begin
            exp_q.push_back(e1);
            i_i2c_ctrl_model.rd_byte(1'b1);
        end
        i_i2c_ctrl_model.stop();
    endtask
    // frame the target must refuse; last byte sent is not acked
    task automatic refused(input logic [7:0] b0, input logic [7:0] b1,
                           input logic two);
        i_i2c_ctrl_model.start();
        i_i2c_ctrl_model.wr_byte(b0, a);
        if (two) i_i2c_ctrl_model.wr_byte(b1, a);
        cmp1("nack", 1'b0, a);
        i_i2c_ctrl_model.stop();
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // read watcher: each byte seen retires the oldest note
    always @(posedge clk) begin
        if (rd_v === 1'b1) begin
            cmp1("rd_noted", 1'b1, exp_q.size() != 0);
            if (exp_q.size() != 0) cmp8("rd_byte", exp_q.pop_front(), rd_d);
        end
    end
    // watchdog well beyond the expected run of about 10k cycles
    initial begin
        #3000000;
        err_count++;
        summarize();
    end

    initial begin
        rst_b = 1'b0; clr_n = 1'b1; pgood = 1'b1;
        ext0 = 8'h00; ext1 = 8'h00;
        tick(10);
        rst_b <= 1'b1;
        tick(20);
        cmp8("oe0", 8'h00, oe0);
        cmp8("oe1", 8'h00, oe1);
        cmp1("alert_n", 1'b1, alert_n);
        refused(adr(1'b1), 8'h00, 1'b0);
        refused(adr(1'b0) ^ 8'h02, 8'h00, 1'b0);
        refused(adr(1'b0), 8'h12, 1'b1);
        for (int i = 1; i < 6; i++) rd_regs({i[2:0], 1'b0}, DFLT[i], DFLT[i], 1'b1);
        // random pin levels through the polarity stage
        ext0 <= 8'($random(seed));
        ext1 <= 8'($random(seed));
        pol0 = 8'($random(seed));
        wr_pair(REG_POL0, pol0, 8'h00);
        rd_regs(REG_IN0, ext0 ^ pol0, ext1, 1'b1);
        rd_regs(REG_IN1, ext1, ext0 ^ pol0, 1'b1);
        cmp1("alert_n", 1'b1, alert_n);
        // random direction, push-pull then open-drain
        out0 = 8'($random(seed));
        dir0 = 8'($random(seed));
        wr_pair(REG_OUT0, out0, 8'h5a);
        wr_pair(REG_CFG0, dir0, 8'hff);
        tick(2);
        cmp8("oe0", ~dir0, oe0);
        cmp8("lvl0", out0 & ~dir0, o0 & ~dir0);
        rd_regs(REG_IN0, ((out0 & ~dir0) | (ext0 & dir0)) ^ pol0, ext1, 1'b1);
        wr_pair(REG_MODE0, 8'hff, 8'h00);
        tick(2);
        cmp8("oe0_od", ~dir0 & ~out0, oe0);
        cmp8("lvl0_od", 8'h00, o0 & oe0);
        rd_regs(REG_OUT0, out0, 8'h5a, 1'b1);
        wr_pair(REG_CFG0, 8'hff, 8'hff);
        wr_pair(REG_MODE0, 8'h00, 8'h00);
        wr_pair(REG_POL0, 8'h00, 8'h00);
        rd_regs(REG_IN0, ext0, ext1, 1'b1);
        cmp1("alert_n", 1'b1, alert_n);
        // input change alert, per-lane release, foreign traffic
        ext0 <= ext0 ^ 8'h10;
        tick(6);
        cmp1("alert_n", 1'b0, alert_n);
        ext0 <= ext0 ^ 8'h10;
        tick(6);
        cmp1("alert_n", 1'b1, alert_n);
        ext0 <= ext0 ^ 8'h01;
        refused(adr(1'b0) ^ 8'h04, 8'h00, 1'b0);
        cmp1("alert_n", 1'b0, alert_n);
        rd_regs(REG_IN1, ext1, ext0, 1'b0);
        cmp1("alert_n", 1'b0, alert_n);
        rd_regs(REG_IN0, ext0, ext1, 1'b0);
        cmp1("alert_n", 1'b1, alert_n);
        // output anomaly on a released open-drain pin of lane 1
        ext1 <= 8'hfe;
        rd_regs(REG_IN1, 8'hfe, ext0, 1'b0);
        wr_pair(REG_OUT0, 8'hff, 8'hff);
        wr_pair(REG_MODE0, 8'h00, 8'h01);
        wr_pair(REG_CFG0, 8'hff, 8'hfe);
        tick(6);
        cmp1("alert_n", 1'b1, alert_n);
        wr_pair(REG_ANOM0, 8'h00, 8'h01);
        tick(6);
        cmp1("alert_n", 1'b0, alert_n);
        ext1 <= 8'hff;
        tick(6);
        cmp1("alert_n", 1'b1, alert_n);
        // hardware clear in mid-frame, held by the controller side
        wr_pair(REG_MODE0, 8'h00, 8'h00);
        tick(2);
        cmp8("oe1", 8'h01, oe1);
        i_i2c_ctrl_model.start();
        i_i2c_ctrl_model.wr_byte(adr(1'b0), a);
        clr_n <= 1'b0;
        tick(8);
        cmp8("oe1_clr", 8'h00, oe1);
        clr_n <= 1'b1;
        tick(12);
        i_i2c_ctrl_model.stop();
        refused(adr(1'b1), 8'h00, 1'b0);
        rd_regs(REG_CFG0, RST_CFG, RST_CFG, 1'b1);
        // power-good drop holds reset, defaults afterwards
        wr_pair(REG_CFG0, 8'h00, 8'hff);
        tick(2);
        cmp8("oe0", 8'hff, oe0);
        pgood <= 1'b0;
        tick(8);
        cmp8("oe0_pg", 8'h00, oe0);
        pgood <= 1'b1;
        tick(12);
        rd_regs(REG_OUT0, RST_OUT, RST_OUT, 1'b1);
        tick(20);
        cmp1("q_empty", 1'b1, exp_q.size() == 0);
        summarize();
    end
endmodule

`default_nettype wire
